/* mss_defines.svh */
// constants for the multiplexed scan sequencing block
`ifndef MSS_DEFINES_SVH
`define MSS_DEFINES_SVH
`define MSS_ADDR_CFG 8'h00
`define MSS_ADDR_HSC 8'h04
`define MSS_ADDR_FIFO 8'h08
`define MSS_ADDR_STAT 8'h0C
`define MSS_CFG_RST 16'h0000
`define MSS_HSC_RST 8'h00
`define MSS_HSC_CLEAR 8'h00
`define MSS_HSC_LOAD 8'h08
`define MSS_B_DRV 0
`define MSS_B_SCSEL 2
`define MSS_B_OUTBUF 5
`define MSS_B_CCC_LO 8
`define MSS_B_CCC_HI 10
`define MSS_B_MODE_LO 14
`define MSS_B_MODE_HI 15
`define MSS_MODE_HOST 2'b10
`define MSS_MODE_SEC 2'b01
`define MSS_H_EN 0
`define MSS_H_RUN 1
`define MSS_H_ONESHOT 4
`define MSS_H_CLRPTR 6
`define MSS_H_ARM 7
`define MSS_LIST_DEPTH 16
`define MSS_LIST_AW 4
`define MSS_CNT_W 7
`define MSS_SLOT_W 4
`define MSS_SLOT_DUMMY 4'hD
`define MSS_SLOT_SELF 4'h1
`endif

/* mss_host_model.sv */
// host board model: pacing clock and trigger line pulses
`timescale 1ns/100ps
`default_nettype none
module mss_host_model (
    input wire logic clk_i, // clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic [1:0] go_i, // start pulse, bit 0 pacing, bit 1 trigger
    output logic pace_n_o, // pacing clock, idles high
    output logic trig_o // trigger drive value, idles high (pulled up)
);
    logic [3:0] cnt_ff, nxt_cnt;
    logic [1:0] sel_ff, nxt_sel;
    always_comb
    begin
        nxt_cnt = (cnt_ff != 4'h0) ? cnt_ff - 4'h1 : 4'h0;
        nxt_sel = sel_ff;
        if (go_i != 2'b00)
        begin
            nxt_cnt = 4'h8;
            nxt_sel = go_i;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_ff <= 4'h0;
            sel_ff <= 2'b00;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            sel_ff <= nxt_sel;
        end
    end
    // four low then four high: one clean falling edge per sample past the synchroniser
    assign pace_n_o = !(sel_ff[0] && cnt_ff > 4'h4);
    assign trig_o = !(sel_ff[1] && cnt_ff > 4'h4);
endmodule : mss_host_model
`default_nettype wire

/* mss_pkg.sv */
// types for the multiplexed scan sequencing block
package mss_pkg;
    typedef enum logic [1:0] {
        MSS_IDLE = 2'b00,
        MSS_LOAD = 2'b01,
        MSS_RUN = 2'b10
    } mss_state_t;
endpackage : mss_pkg

/* mss_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module mss_sync (
    input wire logic clk_i, // clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic d_i, // asynchronous level
    output logic q_o // synchronised level
);
    logic s1_ff;
    logic s2_ff;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
        end
        else
        begin
            s1_ff <= d_i;
            s2_ff <= s1_ff;
        end
    end
    assign q_o = s2_ff;
endmodule : mss_sync
`default_nettype wire

/* mss_top.sv */
// module configuration, scan-list sequencer and axi4-lite register slave
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "mss_defines.svh"
module mss_top
    import mss_pkg::*;
(
    input wire logic clk_i, // 10 MHz clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic conversion_pacing_clock_n_i, // host scan clock pin
    input wire logic backplane_trigger_zero_i, // trigger line zero pin
    input wire logic scan_select_n_i, // scan select pin, active low
    output logic backplane_trigger_zero_o, // trigger zero drive value
    output logic backplane_trigger_zero_oe_o, // trigger zero drive enable
    output logic line_zero_drive_o, // drive shared analog line zero
    output logic muxed_output_channel_fwd_o, // line zero to muxed output
    output logic [2:0] channel_pointer_o, // current channel pointer
    output logic [3:0] scan_slot_o, // slot addressed by current entry
    output logic scan_active_o // sequencer running
);
    logic pace_s, trig_s, ssel_s;
    mss_sync u_pace (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(conversion_pacing_clock_n_i), .q_o(pace_s));
    mss_sync u_trig (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(backplane_trigger_zero_i), .q_o(trig_s));
    mss_sync u_ssel (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(scan_select_n_i), .q_o(ssel_s));

    // bus slave: write and read channels
    logic aw_ff, w_ff, bv_ff, rv_ff;
    logic [7:0] awa_ff;
    logic [31:0] wd_ff, rd_ff;
    logic [3:0] ws_ff;
    logic [1:0] br_ff, rr_ff;
    logic nxt_aw, nxt_w, nxt_bv, nxt_rv;
    logic [7:0] nxt_awa;
    logic [31:0] nxt_wd, nxt_rd;
    logic [3:0] nxt_ws;
    logic [1:0] nxt_br, nxt_rr;
    logic wr_go, rd_go;
    logic [15:0] cfg_ff, nxt_cfg;
    logic [7:0] hsc_ff, nxt_hsc;
    logic [10:0] list_mem [`MSS_LIST_DEPTH];
    logic [`MSS_LIST_AW:0] wcnt_ff, nxt_wcnt;
    logic [`MSS_LIST_AW-1:0] rptr_ff, nxt_rptr;
    logic [`MSS_CNT_W-1:0] left_ff, nxt_left;
    logic [2:0] chan_ff, nxt_chan;
    logic [3:0] slot_ff, nxt_slot;
    logic clk_prev_ff, nxt_clk_prev;
    logic hsc_wr_ff, nxt_hsc_wr;
    mss_state_t st_ff, nxt_st;
    logic fifo_wr, clk_edge, last_entry;
    logic [1:0] mode;
    logic secondary, host_side, scan_en, gated;

    assign wr_go = aw_ff && w_ff && !bv_ff;
    assign fifo_wr = wr_go && awa_ff == `MSS_ADDR_FIFO && st_ff == MSS_LOAD && !wcnt_ff[`MSS_LIST_AW];

    always_comb
    begin
        nxt_aw = aw_ff;
        nxt_w = w_ff;
        nxt_awa = awa_ff;
        nxt_wd = wd_ff;
        nxt_ws = ws_ff;
        nxt_bv = bv_ff;
        nxt_br = br_ff;
        nxt_cfg = cfg_ff;
        nxt_hsc = hsc_ff;
        nxt_hsc_wr = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            nxt_aw = 1'b1;
            nxt_awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            nxt_w = 1'b1;
            nxt_wd = s_axi_wdata;
            nxt_ws = s_axi_wstrb;
        end
        if (wr_go)
        begin
            nxt_aw = 1'b0;
            nxt_w = 1'b0;
            nxt_bv = 1'b1;
            nxt_br = 2'b00;
            unique case (awa_ff)
                `MSS_ADDR_CFG:
                begin
                    if (ws_ff[0]) nxt_cfg[7:0] = wd_ff[7:0];
                    if (ws_ff[1]) nxt_cfg[15:8] = wd_ff[15:8];
                end
                `MSS_ADDR_HSC:
                begin
                    if (ws_ff[0])
                    begin
                        nxt_hsc = wd_ff[7:0];
                        nxt_hsc_wr = 1'b1;
                    end
                end
                `MSS_ADDR_FIFO:
                begin
                    // a full list or write outside the load phase is refused
                    if (!fifo_wr) nxt_br = 2'b10;
                end
                `MSS_ADDR_STAT:
                begin
                    nxt_br = 2'b00;
                end
                default: nxt_br = 2'b10;
            endcase
        end
        if (bv_ff && s_axi_bready)
            nxt_bv = 1'b0;
    end

    assign s_axi_awready = !aw_ff && !bv_ff;
    assign s_axi_wready = !w_ff && !bv_ff;
    assign s_axi_bvalid = bv_ff;
    assign s_axi_bresp = br_ff;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !rv_ff;
    assign s_axi_rvalid = rv_ff;
    assign s_axi_rdata = rd_ff;
    assign s_axi_rresp = rr_ff;

    always_comb
    begin
        nxt_rv = rv_ff;
        nxt_rd = rd_ff;
        nxt_rr = rr_ff;
        if (rd_go)
        begin
            nxt_rv = 1'b1;
            nxt_rr = 2'b00;
            nxt_rd = 32'h0000_0000;
            unique case (s_axi_araddr)
                `MSS_ADDR_CFG: nxt_rd[15:0] = cfg_ff;
                `MSS_ADDR_HSC: nxt_rd[7:0] = hsc_ff;
                `MSS_ADDR_FIFO: nxt_rd[`MSS_LIST_AW:0] = wcnt_ff;
                `MSS_ADDR_STAT: nxt_rd[11:0] = {slot_ff, chan_ff, line_zero_drive_o, st_ff, rptr_ff[1:0]};
                default: nxt_rr = 2'b10;
            endcase
        end
        else if (rv_ff && s_axi_rready)
            nxt_rv = 1'b0;
    end

    // configuration decode
    assign mode = cfg_ff[`MSS_B_MODE_HI:`MSS_B_MODE_LO];
    assign secondary = mode == `MSS_MODE_SEC;
    assign host_side = mode == `MSS_MODE_HOST;
    assign scan_en = cfg_ff[`MSS_B_SCSEL];
    // drive passes when scan select is disabled, or when enabled and asserted low
    assign gated = scan_en ? !ssel_s : 1'b1;
    // output-buffer routing means line zero is received, never driven
    assign line_zero_drive_o = cfg_ff[`MSS_B_DRV] && !cfg_ff[`MSS_B_OUTBUF] && gated;
    // forwarding via output buffer or config bit 1 when bus line zero is routed to host
    assign muxed_output_channel_fwd_o = host_side && (cfg_ff[`MSS_B_OUTBUF] || cfg_ff[1]);
    assign backplane_trigger_zero_o = pace_s;
    assign backplane_trigger_zero_oe_o = host_side && cfg_ff[`MSS_B_DRV] && cfg_ff[1];

    // scan sequencer: clock source picked per configuration
    assign clk_edge = (secondary ? trig_s : pace_s) == 1'b0 && clk_prev_ff;
    assign last_entry = {1'b0, rptr_ff} == wcnt_ff - 5'd1;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_wcnt = wcnt_ff;
        nxt_rptr = rptr_ff;
        nxt_left = left_ff;
        nxt_chan = chan_ff;
        nxt_slot = slot_ff;
        nxt_clk_prev = secondary ? trig_s : pace_s;
        if (fifo_wr)
            nxt_wcnt = wcnt_ff + 5'd1;
        unique case (st_ff)
            MSS_IDLE:
            begin
                if (hsc_ff[`MSS_H_ARM] && hsc_ff[`MSS_H_CLRPTR])
                    nxt_rptr = '0;
                else if (hsc_ff == `MSS_HSC_LOAD)
                begin
                    // load phase appends; only a zero write empties the list, so a rerun keeps it
                    nxt_st = MSS_LOAD;
                end
                else if (hsc_wr_ff && hsc_ff[`MSS_H_EN] && hsc_ff[`MSS_H_RUN] && wcnt_ff != 5'd0)
                begin
                    nxt_st = MSS_RUN;
                    nxt_rptr = '0;
                    {nxt_slot, nxt_left} = list_mem[0];
                    nxt_chan = cfg_ff[`MSS_B_CCC_HI:`MSS_B_CCC_LO];
                end
            end
            MSS_LOAD:
            begin
                if (hsc_ff[`MSS_H_CLRPTR])
                    nxt_st = MSS_IDLE;
                else if (hsc_ff[5])
                    nxt_st = MSS_IDLE;
            end
            MSS_RUN:
            begin
                if (!hsc_ff[`MSS_H_EN])
                    nxt_st = MSS_IDLE;
                else if (clk_edge)
                begin
                    nxt_chan = chan_ff + 3'd1;
                    if (left_ff != '0)
                        nxt_left = left_ff - 7'd1;
                    else
                    begin
                        if (last_entry && hsc_ff[`MSS_H_ONESHOT])
                            nxt_st = MSS_IDLE;
                        nxt_rptr = last_entry ? '0 : rptr_ff + 4'd1;
                        {nxt_slot, nxt_left} = list_mem[last_entry ? 4'd0 : rptr_ff + 4'd1];
                        nxt_chan = cfg_ff[`MSS_B_CCC_HI:`MSS_B_CCC_LO];
                    end
                end
            end
            default: nxt_st = MSS_IDLE;
        endcase
        // start needs a fresh write, so a finished one-shot run stays stopped
        if (hsc_wr_ff && hsc_ff == `MSS_HSC_CLEAR)
            nxt_wcnt = '0;
    end

    always_ff @(posedge clk_i)
    begin
        if (fifo_wr)
            list_mem[wcnt_ff[`MSS_LIST_AW-1:0]] <= wd_ff[10:0];
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awa_ff <= 8'h00;
            wd_ff <= 32'h0000_0000;
            ws_ff <= 4'h0;
            bv_ff <= 1'b0;
            br_ff <= 2'b00;
            rv_ff <= 1'b0;
            rd_ff <= 32'h0000_0000;
            rr_ff <= 2'b00;
            cfg_ff <= `MSS_CFG_RST;
            hsc_ff <= `MSS_HSC_RST;
            st_ff <= MSS_IDLE;
            wcnt_ff <= '0;
            rptr_ff <= '0;
            left_ff <= '0;
            chan_ff <= 3'h0;
            slot_ff <= 4'h0;
            clk_prev_ff <= 1'b1;
            hsc_wr_ff <= 1'b0;
        end
        else
        begin
            aw_ff <= nxt_aw;
            w_ff <= nxt_w;
            awa_ff <= nxt_awa;
            wd_ff <= nxt_wd;
            ws_ff <= nxt_ws;
            bv_ff <= nxt_bv;
            br_ff <= nxt_br;
            rv_ff <= nxt_rv;
            rd_ff <= nxt_rd;
            rr_ff <= nxt_rr;
            cfg_ff <= nxt_cfg;
            hsc_ff <= nxt_hsc;
            st_ff <= nxt_st;
            wcnt_ff <= nxt_wcnt;
            rptr_ff <= nxt_rptr;
            left_ff <= nxt_left;
            chan_ff <= nxt_chan;
            slot_ff <= nxt_slot;
            clk_prev_ff <= nxt_clk_prev;
            hsc_wr_ff <= nxt_hsc_wr;
        end
    end

    assign channel_pointer_o = chan_ff;
    assign scan_slot_o = slot_ff;
    assign scan_active_o = st_ff == MSS_RUN;
endmodule : mss_top
`default_nettype wire

/* mss_top_asserts.sv */
// register-port and pin checks for the scan sequencer
`timescale 1ns/100ps
`default_nettype none
module mss_top_asserts (
    input wire logic clk_i, // clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b response
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [1:0] s_axi_rresp, // r response
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic backplane_trigger_zero_oe_o, // trigger drive enable
    input wire logic muxed_output_channel_fwd_o // line zero forwarded
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    a_write_answer: assert property (s_both_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    a_b_holds: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
        else $error("read data dropped early");
    a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_resp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
        else $error("illegal write response code");
    a_trig_fwd: assert property (backplane_trigger_zero_oe_o |-> muxed_output_channel_fwd_o)
        else $error("trigger driven without forwarding");
endmodule : mss_top_asserts
bind mss_top mss_top_asserts mss_top_asserts_i (.clk_i, .rst_n_i, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .backplane_trigger_zero_oe_o,
    .muxed_output_channel_fwd_o);
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the scan sequencer
`timescale 1ns/100ps
`default_nettype none
`include "mss_defines.svh"
module tb_top;
    logic clk_i, rst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, scan_select_n_i;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, scan_slot_o;
    logic [1:0] s_axi_bresp, s_axi_rresp, go;
    logic trig_o, trig_oe, line_zero_drive_o, fwd, scan_active_o, pace_n, model_trig;
    logic [2:0] channel_pointer_o;
    wire logic trig_w;
    int failures, checked;
    logic [7:0] hsc_new [2] = '{8'h00, 8'h08};
    logic [7:0] hsc_go [4] = '{8'h2C, 8'hBC, 8'hBE, 8'hBF};
    logic [7:0] hsc_again [7] = '{8'h08, 8'h48, 8'h08, 8'h2C, 8'hAC, 8'hAE, 8'hAF};
    assign trig_w = trig_oe ? trig_o : model_trig;
    always #50 clk_i = ~clk_i;
    mss_top mss_top_i (.clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .conversion_pacing_clock_n_i(pace_n), .backplane_trigger_zero_i(trig_w),
        .scan_select_n_i, .backplane_trigger_zero_o(trig_o), .backplane_trigger_zero_oe_o(trig_oe),
        .line_zero_drive_o, .muxed_output_channel_fwd_o(fwd), .channel_pointer_o, .scan_slot_o,
        .scan_active_o);
    mss_host_model mss_host_model_i (.clk_i, .rst_n_i, .go_i(go), .pace_n_o(pace_n), .trig_o(model_trig));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // each write waits for its write response, so no two writes merge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        tb = 1'b0;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        repeat (50)
        begin
            @(negedge clk_i);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk_i);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb)
            begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
        cmp({29'h0, tb, r}, {29'h0, 1'b1, er});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        tr = 1'b0;
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        repeat (50)
        begin
            @(negedge clk_i);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_i);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr)
            begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
        cmp({29'h0, tr, r}, {29'h0, 1'b1, er});
        if (er == 2'b00) cmp(d, ed);
    endtask : rd
    task automatic pins(input logic [2:0] e);
        repeat (4) @(posedge clk_i);
        cmp({29'h0, line_zero_drive_o, fwd, trig_oe}, {29'h0, e});
    endtask : pins
    task automatic scan(input logic [7:0] e, input logic [7:0] m);
        cmp({24'h0, {scan_active_o, scan_slot_o, channel_pointer_o} & m}, {24'h0, e & m});
    endtask : scan
    task automatic pulse(input logic [1:0] w, input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            go <= w;
            @(posedge clk_i);
            go <= 2'b00;
            repeat (14) @(posedge clk_i);
        end
    endtask : pulse
    task automatic give_verdict;
        if (failures == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    initial
    begin
        #3_000_000;
        failures++;
        give_verdict();
    end
    initial
    begin
        {clk_i, rst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, go} = '0;
        s_axi_wstrb = 4'hF;
        scan_select_n_i = 1'b1;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(`MSS_ADDR_CFG, 32'h0000_0000, 2'b00);
        rd(`MSS_ADDR_HSC, 32'h0000_0000, 2'b00);
        rd(8'h10, 32'h0000_0000, 2'b10);
        wr(8'h10, 32'h0000_0000, 2'b10);
        wr(`MSS_ADDR_CFG, 32'h0000_430F, 2'b00);
        pins(3'b000);
        scan_select_n_i <= 1'b0;
        pins(3'b100);
        wr(`MSS_ADDR_CFG, 32'h0000_430E, 2'b00);
        pins(3'b000);
        scan_select_n_i <= 1'b1;
        wr(`MSS_ADDR_CFG, 32'h0000_8023, 2'b00);
        pins(3'b011);
        wr(`MSS_ADDR_CFG, 32'h0000_850F, 2'b00);
        pins(3'b011);
        scan_select_n_i <= 1'b0;
        pins(3'b111);
        scan_select_n_i <= 1'b1;
        foreach (hsc_new[i]) wr(`MSS_ADDR_HSC, {24'h0, hsc_new[i]}, 2'b00);
        wr(`MSS_ADDR_FIFO, 32'h0000_0081, 2'b00);
        wr(`MSS_ADDR_FIFO, 32'h0000_0680, 2'b00);
        wr(`MSS_ADDR_FIFO, 32'h0000_0081, 2'b00);
        foreach (hsc_go[i]) wr(`MSS_ADDR_HSC, {24'h0, hsc_go[i]}, 2'b00);
        pins(3'b011);
        scan({1'b1, 4'h1, 3'h5}, 8'hFF);
        wr(`MSS_ADDR_FIFO, 32'h0000_0081, 2'b10);
        pulse(2'b01, 2);
        scan({1'b1, 4'hD, 3'h0}, 8'hF8);
        pulse(2'b01, 1);
        scan({1'b1, 4'h1, 3'h5}, 8'hFF);
        pulse(2'b01, 1);
        scan({1'b1, 4'h1, 3'h6}, 8'hFF);
        pulse(2'b01, 1);
        scan({1'b0, 7'h0}, 8'h80);
        foreach (hsc_again[i]) wr(`MSS_ADDR_HSC, {24'h0, hsc_again[i]}, 2'b00);
        pins(3'b011);
        pulse(2'b01, 5);
        scan({1'b1, 4'h1, 3'h5}, 8'hFF);
        wr(`MSS_ADDR_CFG, 32'h0000_450F, 2'b00);
        pins(3'b000);
        pulse(2'b01, 1);
        scan({1'b1, 4'h1, 3'h5}, 8'hFF);
        pulse(2'b10, 1);
        scan({1'b1, 4'h1, 3'h6}, 8'hFF);
        wr(`MSS_ADDR_HSC, 32'h0000_0000, 2'b00);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
